// file: logic/ifd_pkg.sv
// Purpose: shared constants and types for the interlock fault diagnostics block
// Assumes: core_clk at 200 MHz
// Notes: long times are top-level parameters so simulation can shorten them
`default_nettype none
package ifd_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int WARN_MIN = 30;
    localparam longint WARN_CYC = longint'(WARN_MIN) * 60 * CLK_HZ;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int PAUSE_SLOTS = 6;
    localparam int LOCK_LIMIT = 1_000_000;
    localparam int ACT_LIMIT = 500_000;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_OUT_A = 4'h1;
    localparam logic [3:0] CODE_OUT_B = 4'h2;
    localparam logic [3:0] CODE_CROSS = 4'h3;
    localparam logic [3:0] CODE_TEMP = 4'h4;
    localparam logic [3:0] CODE_ACT = 4'h5;
    localparam logic [3:0] CODE_CTRL = 4'h6;
    localparam logic [3:0] CODE_LOCK = 4'h7;
    localparam logic [3:0] CODE_SUPPLY = 4'h8;

    typedef struct packed {
        logic out_a_fault;
        logic out_b_fault;
        logic cross_short;
        logic over_temp;
        logic wrong_actuator;
        logic ctrl_input_err;
        logic lock_blocked;
        logic supply_fault;
        logic defective;
        logic input_a_err;
        logic input_b_err;
    } ifd_fault_t;

    typedef struct packed {
        logic red;
        logic green;
    } ifd_led_t;
endpackage : ifd_pkg
`default_nettype wire

// file: logic/ifd_blinker.sv
// Purpose: red blink-code generator, n pulses then a long dark pause
// Assumes: code stable for a group; zero code gives dark
// Notes: code is sampled only at group start so groups never tear
`timescale 1ns/1ps
`default_nettype none
module ifd_blinker #(
    parameter int SLOT_CYC = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] code,
    output logic led
);
    import ifd_pkg::*;
    logic [31:0] tick_r, tick_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic [3:0] cur_r, cur_nxt;
    logic led_r, led_nxt;

    always_comb begin
        tick_nxt = tick_r;
        slot_nxt = slot_r;
        cur_nxt = cur_r;
        led_nxt = led_r;
        if (tick_r == 32'(SLOT_CYC - 1)) begin
            tick_nxt = '0;
            // group is 2 slots per pulse, then a pause
            if (slot_r >= 5'({cur_r, 1'b0}) + 5'(PAUSE_SLOTS) - 5'h01) begin
                slot_nxt = '0;
                cur_nxt = code;
            end else begin
                slot_nxt = slot_r + 5'h01;
            end
        end else begin
            tick_nxt = tick_r + 32'h1;
        end
        led_nxt = (slot_nxt < 5'({cur_nxt, 1'b0})) && !slot_nxt[0] && (cur_nxt != CODE_NONE);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tick_r <= '0;
            slot_r <= '0;
            cur_r <= CODE_NONE;
            led_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
            slot_r <= slot_nxt;
            cur_r <= cur_nxt;
            led_r <= led_nxt;
        end
    end
    assign led = led_r;
endmodule : ifd_blinker
`default_nettype wire

// file: logic/ifd_diag.sv
// Purpose: fault classification, shutdown timing, lockout, wear and led indication
// Assumes: fault inputs synchronous, level; guard_open high while the guard is open
// Notes: reset stands for a power cycle, the only way out of lockout
// Notes on behaviour
// - output a test fault or stray voltage: warning, one red pulse per group
// - output b test fault or stray voltage: warning, two red pulses per group
// - cross short or both outputs faulty: lockout, three red pulses
// - over temperature warns with four pulses; bad supply warns with eight
// - warning active for thirty minutes switches safety outputs off
// - actuator, control input, locking faults disable at once; defective shows steady red
// - safety input error: green blinks, red off, outputs follow system state
// - wear limit reached: refuse locking, alternate green and red, outputs off
// - latched error clears only when guard opens after cause is gone
// - multiple output faults or cross short lock out until power cycle
`timescale 1ns/1ps
`default_nettype none
module ifd_diag #(
    parameter longint WARN_TIME_CYC = ifd_pkg::WARN_CYC,
    parameter int BLINK_SLOT_CYC = ifd_pkg::BLINK_CYC,
    parameter int LOCK_CYCLE_LIMIT = ifd_pkg::LOCK_LIMIT,
    parameter int ACT_CYCLE_LIMIT = ifd_pkg::ACT_LIMIT
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire ifd_pkg::ifd_fault_t faults,
    input wire logic guard_open,
    input wire logic system_enable,
    input wire logic lock_request,
    input wire logic lock_event,
    input wire logic actuator_event,
    output logic safety_output_a,
    output logic safety_output_b,
    output logic diag_out,
    output logic lock_allowed,
    output var ifd_pkg::ifd_led_t leds,
    output logic warning,
    output logic lockout
);
    import ifd_pkg::*;

    typedef enum {ST_RUN, ST_WARN, ST_ERROR, ST_LOCKOUT, ST_WORN} ifd_state_t;
    ifd_state_t state_r, state_nxt;
    logic [63:0] warn_cnt_r, warn_cnt_nxt;
    logic [19:0] lock_cnt_r, lock_cnt_nxt;
    logic [19:0] act_cnt_r, act_cnt_nxt;
    logic [3:0] code_r, code_nxt;
    logic [31:0] slow_r, slow_nxt;
    logic phase_r, phase_nxt;
    logic outs_r, outs_nxt;
    logic grn_r, grn_nxt;
    logic red_r, red_nxt;
    logic red_blink;
    logic warn_any, err_any, worn, multi_out;
    logic [3:0] warn_code, err_code;

    // warning class, lowest code wins when several are present, except cross short beats the output a and b codes
    always_comb begin
        warn_code = CODE_NONE;
        if (faults.supply_fault) warn_code = CODE_SUPPLY;
        if (faults.over_temp) warn_code = CODE_TEMP;
        if (faults.cross_short || (faults.out_a_fault && faults.out_b_fault))
            warn_code = CODE_CROSS;
        else if (faults.out_b_fault) warn_code = CODE_OUT_B;
        else if (faults.out_a_fault) warn_code = CODE_OUT_A;
        warn_any = warn_code != CODE_NONE;
        err_code = CODE_NONE;
        if (faults.lock_blocked) err_code = CODE_LOCK;
        if (faults.ctrl_input_err) err_code = CODE_CTRL;
        if (faults.wrong_actuator) err_code = CODE_ACT;
        err_any = (err_code != CODE_NONE) || faults.defective;
        multi_out = faults.cross_short || (faults.out_a_fault && faults.out_b_fault);
        worn = (lock_cnt_r >= 20'(LOCK_CYCLE_LIMIT)) || (act_cnt_r >= 20'(ACT_CYCLE_LIMIT));
    end

    always_comb begin
        state_nxt = state_r;
        warn_cnt_nxt = warn_cnt_r;
        code_nxt = code_r;
        lock_cnt_nxt = lock_cnt_r;
        act_cnt_nxt = act_cnt_r;
        if (lock_event && lock_cnt_r < 20'(LOCK_CYCLE_LIMIT)) lock_cnt_nxt = lock_cnt_r + 20'h1;
        if (actuator_event && act_cnt_r < 20'(ACT_CYCLE_LIMIT)) act_cnt_nxt = act_cnt_r + 20'h1;
        case (state_r)
            ST_RUN: begin
                warn_cnt_nxt = '0;
                if (worn) state_nxt = ST_WORN;
                else if (multi_out) begin
                    state_nxt = ST_LOCKOUT;
                    code_nxt = CODE_CROSS;
                end else if (err_any) begin
                    state_nxt = ST_ERROR;
                    code_nxt = err_code;
                end else if (warn_any) begin
                    state_nxt = ST_WARN;
                    code_nxt = warn_code;
                end
            end
            ST_WARN: begin
                if (warn_cnt_r < 64'(WARN_TIME_CYC)) warn_cnt_nxt = warn_cnt_r + 64'h1;
                if (worn) state_nxt = ST_WORN;
                else if (multi_out) begin
                    state_nxt = ST_LOCKOUT;
                    code_nxt = CODE_CROSS;
                end else if (err_any) begin
                    state_nxt = ST_ERROR;
                    code_nxt = err_code;
                end else if (!warn_any && warn_cnt_r < 64'(WARN_TIME_CYC)) begin
                    state_nxt = ST_RUN; // warning drops with its cause while outputs still on
                    code_nxt = CODE_NONE;
                end else if (!warn_any && guard_open) begin
                    state_nxt = ST_RUN;
                    code_nxt = CODE_NONE;
                end else if (warn_any) begin
                    code_nxt = warn_code;
                end
            end
            ST_ERROR: begin
                if (multi_out) begin
                    state_nxt = ST_LOCKOUT;
                    code_nxt = CODE_CROSS;
                end else if (!err_any && !warn_any && guard_open) begin
                    state_nxt = ST_RUN;
                    code_nxt = CODE_NONE;
                end else if (err_any) begin
                    code_nxt = err_code; // the lowest present error code replaces the shown code
                end
            end
            ST_LOCKOUT: begin
                // only a power cycle leaves; guard_open is ignored on purpose
                state_nxt = ST_LOCKOUT;
            end
            ST_WORN: begin
                state_nxt = ST_WORN;
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // outputs and leds
    always_comb begin
        slow_nxt = slow_r + 32'h1;
        phase_nxt = phase_r;
        if (slow_r >= 32'(BLINK_SLOT_CYC * 2 - 1)) begin
            slow_nxt = '0;
            phase_nxt = !phase_r;
        end
        outs_nxt = system_enable;
        grn_nxt = 1'b1;
        red_nxt = 1'b0;
        case (state_r)
            ST_RUN: red_nxt = 1'b0;
            ST_WARN: begin
                outs_nxt = system_enable && (warn_cnt_r < 64'(WARN_TIME_CYC));
                red_nxt = red_blink;
            end
            ST_ERROR: begin
                outs_nxt = 1'b0;
                red_nxt = faults.defective ? 1'b1 : red_blink;
            end
            ST_LOCKOUT: begin
                outs_nxt = 1'b0;
                red_nxt = red_blink;
            end
            ST_WORN: begin
                outs_nxt = 1'b0;
                grn_nxt = phase_r;
                red_nxt = !phase_r;
            end
            default: outs_nxt = 1'b0;
        endcase
        // input circuit fault: green blinks, red dark, outputs untouched
        if (state_r == ST_RUN && (faults.input_a_err || faults.input_b_err)) begin
            grn_nxt = phase_r;
            red_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= ST_RUN;
            warn_cnt_r <= '0;
            lock_cnt_r <= '0;
            act_cnt_r <= '0;
            code_r <= CODE_NONE;
            slow_r <= '0;
            phase_r <= 1'b0;
            outs_r <= 1'b0;
            grn_r <= 1'b0;
            red_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            warn_cnt_r <= warn_cnt_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            act_cnt_r <= act_cnt_nxt;
            code_r <= code_nxt;
            slow_r <= slow_nxt;
            phase_r <= phase_nxt;
            outs_r <= outs_nxt;
            grn_r <= grn_nxt;
            red_r <= red_nxt;
        end
    end

    ifd_blinker #(
        .SLOT_CYC(BLINK_SLOT_CYC)
    ) u_blink (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .code(code_r),
        .led(red_blink)
    );

    assign safety_output_a = outs_r;
    assign safety_output_b = outs_r;
    // diag output drops as soon as any warning or error other than a safety input error stands
    assign diag_out = outs_r && (state_r == ST_RUN);
    assign lock_allowed = lock_request && (state_r != ST_WORN) && !worn;
    assign leds = '{red: red_r, green: grn_r};
    assign warning = state_r == ST_WARN;
    assign lockout = state_r == ST_LOCKOUT;
endmodule : ifd_diag
`default_nettype wire

// file: dv/ifd_plc_model.sv
// Purpose: plc side, counts red pulses per blink group
// Assumes: slot of 2 cycles, so a 6 cycle dark run ends a group
// Notes: steady red never ends a group
`timescale 1ns/1ps
`default_nettype none
module ifd_plc_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic red,
    output logic [3:0] pulses,
    output logic group_done
);
    logic red_r;
    logic [3:0] cnt_r;
    logic [7:0] dark_r;
    always_ff @(posedge core_clk) begin
        group_done <= 1'b0;
        if (sys_rst) begin
            cnt_r <= 4'h0;
            dark_r <= 8'h0;
            red_r <= 1'b0;
        end else begin
            red_r <= red;
            dark_r <= red ? 8'h0 : dark_r + 8'h1;
            if (red && !red_r)
                cnt_r <= cnt_r + 4'h1;
            if (dark_r == 8'h6 && cnt_r != 4'h0) begin
                pulses <= cnt_r;
                group_done <= 1'b1;
                cnt_r <= 4'h0;
            end
        end
    end
endmodule : ifd_plc_model
`default_nettype wire

// file: dv/ifd_diag_properties.sv
// Purpose: port checks for the diagnostics block
// Assumes: bound into ifd_diag
// Notes: warning age is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module ifd_diag_properties #(
    parameter longint WARN_TIME_CYC = 50
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire ifd_pkg::ifd_fault_t faults,
    input wire logic lock_request,
    input wire logic system_enable,
    input wire logic safety_output_a,
    input wire logic safety_output_b,
    input wire logic diag_out,
    input wire logic lock_allowed,
    input wire ifd_pkg::ifd_led_t leds,
    input wire logic warning,
    input wire logic lockout
);
    import ifd_pkg::*;
    longint warn_cnt_r;
    longint warn_cnt_nxt;
    always_comb begin
        warn_cnt_nxt = warning ? warn_cnt_r + 1 : 0;
    end
    always_ff @(posedge core_clk) begin
        warn_cnt_r <= sys_rst ? 0 : warn_cnt_nxt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_err_fast_off: assert property ((faults.wrong_actuator || faults.ctrl_input_err || faults.lock_blocked
        || faults.defective) |-> ##2 !safety_output_a) else $error("error did not cut outputs");
    a_warn_early_off: assert property (warning && system_enable && $past(system_enable)
        && $fell(safety_output_a) |-> warn_cnt_r >= WARN_TIME_CYC - 2) else $error("warning cut too early");
    a_warn_shut_down: assert property (warning && warn_cnt_r == WARN_TIME_CYC + 4 |-> !safety_output_a)
        else $error("warning never cut outputs");
    a_warn_diag_off: assert property (warning |-> !diag_out) else $error("diag on in warning");
    a_outs_paired: assert property (safety_output_a == safety_output_b) else $error("outputs differ");
    a_lockout_holds: assert property (lockout |=> lockout) else $error("lockout left");
    a_cross_locks: assert property (faults.cross_short |-> ##[1:2] lockout) else $error("no lockout");
    a_worn_refuse: assert property ($fell(lock_allowed) && lock_request && $past(lock_request)
        |=> !lock_allowed [*8]) else $error("lock allowed after wear");
    a_defect_red: assert property ((faults.defective && !lockout) [*3] |-> leds.red)
        else $error("defect not red");
endmodule : ifd_diag_properties
bind ifd_diag ifd_diag_properties #(.WARN_TIME_CYC(WARN_TIME_CYC)) u_props (.core_clk(core_clk),
    .sys_rst(sys_rst), .faults(faults), .lock_request(lock_request), .system_enable(system_enable),
    .safety_output_a(safety_output_a), .safety_output_b(safety_output_b), .diag_out(diag_out),
    .lock_allowed(lock_allowed), .leds(leds), .warning(warning), .lockout(lockout));
`default_nettype wire

// file: dv/tb_interlock_fault_diagnostics.sv
// Purpose: self-checking bench for the diagnostics block
// Assumes: shortened counts, warn 50, slot 2, wear 5 and 3
// Notes: reset between tests stands for a power cycle
`timescale 1ns/1ps
`default_nettype none
module tb_interlock_fault_diagnostics;
    import ifd_pkg::*;
    localparam int BITS[7] = '{10, 9, 7, 6, 5, 4, 3};
    localparam logic [3:0] CODES[7] = '{CODE_OUT_A, CODE_OUT_B, CODE_TEMP, CODE_ACT, CODE_CTRL, CODE_LOCK, CODE_SUPPLY};
    logic core_clk, sys_rst, guard_open, system_enable, lock_request, lock_event, actuator_event;
    logic out_a, out_b, diag_out, lock_allowed, warning, lockout, grp_done, acc, g0, g1;
    ifd_fault_t faults;
    ifd_led_t leds;
    logic [3:0] pulses;
    logic [3:0] exp_q[$];
    int fail_count = 0;
    int checked = 0;
    logic [31:0] rng = 32'h5ec35150;
    ifd_diag #(.WARN_TIME_CYC(50), .BLINK_SLOT_CYC(2), .LOCK_CYCLE_LIMIT(5), .ACT_CYCLE_LIMIT(3)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .faults(faults), .guard_open(guard_open),
        .system_enable(system_enable), .lock_request(lock_request), .lock_event(lock_event),
        .actuator_event(actuator_event), .safety_output_a(out_a), .safety_output_b(out_b), .diag_out(diag_out),
        .lock_allowed(lock_allowed), .leds(leds), .warning(warning), .lockout(lockout));
    ifd_plc_model plc (.core_clk(core_clk), .sys_rst(sys_rst), .red(leds.red), .pulses(pulses), .group_done(grp_done));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic rst;
        sys_rst <= 1;
        faults <= '0;
        {guard_open, lock_request, lock_event, actuator_event} <= 4'h0;
        system_enable <= 1;
        cyc(20);
        sys_rst <= 0;
        cyc(6);
    endtask : rst
    task automatic guard;
        guard_open <= 1;
        cyc(2);
        guard_open <= 0;
        cyc(4);
    endtask : guard
    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #50us;
        fail_count++;
        stop_test();
    end
    always @(posedge core_clk)
        if (grp_done === 1'b1 && exp_q.size() > 0)
            chk({4'h0, pulses}, {4'h0, exp_q.pop_front()}, "pulses");
    initial begin
        for (int k = 0; k < 7; k++) begin
            logic w;
            w = !(k inside {3, 4, 5});
            rst();
            exp_q.push_back(CODES[k]);
            faults <= ifd_fault_t'(11'h1 << BITS[k]);
            cyc(4);
            chk({5'h0, out_a, warning, diag_out}, {5'h0, w, w, 1'b0}, "early state");
            for (int i = 0; i < 200 && exp_q.size() > 0; i++)
                cyc(1);
            chk(8'(exp_q.size()), 8'h0, "no group");
            cyc(60);
            chk({6'h0, out_a, out_b}, 8'h0, "after timeout");
            guard();
            chk({7'h0, out_a}, 8'h0, "guard while fault");
            faults <= '0;
            cyc(4);
            chk({7'h0, out_a}, 8'h0, "held off");
            guard();
            chk({5'h0, out_a, out_b, diag_out}, 8'h7, "guard clear");
            $display("code %0d done", CODES[k]);
        end
        for (int k = 0; k < 2; k++) begin
            rst();
            exp_q.push_back(CODE_CROSS);
            faults <= k ? 11'h600 : 11'h100;
            cyc(4);
            chk({6'h0, lockout, out_a}, 8'h2, "lockout");
            faults <= '0;
            guard();
            chk({7'h0, lockout}, 8'h1, "lockout kept");
            for (int i = 0; i < 200 && exp_q.size() > 0; i++)
                cyc(1);
            chk(8'(exp_q.size()), 8'h0, "no cross group");
            $display("lockout %0d done", k);
        end
        rst();
        faults <= 11'h004;
        cyc(4);
        acc = 1;
        repeat (10) begin
            cyc(1);
            acc &= leds.red;
        end
        chk({6'h0, acc, out_a}, 8'h2, "defective");
        $display("defective done");
        for (int b = 0; b < 2; b++) begin
            rst();
            faults <= b ? 11'h001 : 11'h002;
            {acc, g0, g1} = 3'h0;
            repeat (100) begin
                cyc(1);
                acc |= leds.red;
                g0 |= !leds.green;
                g1 |= leds.green;
            end
            chk({5'h0, acc, g0, g1}, 8'h3, "input error leds");
        end
        repeat (4) begin
            rng = xs(rng);
            system_enable <= rng[0];
            cyc(4);
            chk({7'h0, out_a}, {7'h0, rng[0]}, "follow state");
        end
        $display("leds done");
        for (int w = 0; w < 2; w++) begin
            rst();
            for (int i = 0; i < (w ? 3 : 5); i++) begin
                rng = xs(rng);
                lock_request <= rng[1];
                cyc(2);
                chk({7'h0, lock_allowed}, {7'h0, rng[1]}, "lock before wear");
                lock_request <= 1;
                if (w)
                    actuator_event <= 1;
                else
                    lock_event <= 1;
                cyc(1);
                {lock_event, actuator_event} <= 2'h0;
            end
            cyc(4);
            chk({5'h0, lock_allowed, out_a, leds.green ^ leds.red}, 8'h1, "worn");
            acc = 1;
            {g0, g1} = 2'h0;
            repeat (20) begin
                cyc(1);
                acc &= leds.green ^ leds.red;
                g0 |= !leds.green;
                g1 |= leds.green;
            end
            chk({5'h0, acc, g0, g1}, 8'h7, "worn alternates");
            $display("wear %0d done", w);
        end
        stop_test();
    end
endmodule : tb_interlock_fault_diagnostics
`default_nettype wire
